//--- rtl/sps_defines.vh
// Constants for the sync pin output select block
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH
// Pipeline depth of the sync path
`define SPS_PIPE_DEPTH      2
// Output selection codes
`define SPS_SEL_W           3
`define SPS_SEL_TRI         3'h0
`define SPS_SEL_SD          3'h1
`define SPS_SEL_PIPE        3'h2
`define SPS_SEL_CODE        3'h3
`define SPS_SEL_CNT         3'h4
// Reset values
`define SPS_RST_PIN         1'b0
`define SPS_RST_OE          1'b0
`endif

//--- rtl/sps_pipe.v
// Fixed-depth delay line for one sync signal
`timescale 1ns/100ps
`default_nettype none
`include "sps_defines.vh"
module sps_pipe (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Data
  input  wire din,
  output wire dout
);
  reg [`SPS_PIPE_DEPTH-1:0] shift_reg;

  always @(posedge clk) begin
    if (!rstn) begin
      shift_reg <= {`SPS_PIPE_DEPTH{1'b0}};
    end else begin
      shift_reg <= {shift_reg[`SPS_PIPE_DEPTH-2:0], din};
    end
  end

  assign dout = shift_reg[`SPS_PIPE_DEPTH-1];
endmodule // sps_pipe
`default_nettype wire

//--- rtl/sps_sync_select.v
// Sync pin output selection for the shared horizontal and vertical pins
`timescale 1ns/100ps
`default_nettype none
`include "sps_defines.vh"
module sps_sync_select (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Control bits
  input  wire sd_sync_out_en,
  input  wire edhd_sync_out_en,
  input  wire edhd_in_fmt_embedded,
  input  wire edhd_hsync_ctrl,
  input  wire edhd_vsync_ctrl,
  input  wire std_interlaced,
  // SD timing
  input  wire sd_hsync,
  input  wire sd_vsync_field,
  // Embedded timing code bits
  input  wire code_h,
  input  wire code_v,
  input  wire code_f,
  // Internal counter pulses
  input  wire hcnt_sync,
  input  wire vcnt_sync,
  // Horizontal pin
  input  wire hsync_pin_i,
  output wire hsync_pin_o,
  output wire hsync_pin_oe,
  // Vertical pin
  input  wire vsync_pin_i,
  output wire vsync_pin_o,
  output wire vsync_pin_oe,
  // External ED/HD sync as received
  output wire edhd_ext_hsync,
  output wire edhd_ext_vsync,
  output wire edhd_ext_valid
);
  // ------------------------------------------------------------
  // Selection decode
  // ------------------------------------------------------------
  function [`SPS_SEL_W-1:0] sps_pick;
    input sd_en;
    input hd_en;
    input fmt;
    input ctrl;
    begin
      if (hd_en) begin
        if (ctrl) begin
          sps_pick = `SPS_SEL_CNT;
        end else if (fmt) begin
          sps_pick = `SPS_SEL_CODE;
        end else begin
          sps_pick = `SPS_SEL_PIPE;
        end
      end else if (sd_en) begin
        sps_pick = `SPS_SEL_SD;
      end else begin
        sps_pick = `SPS_SEL_TRI;
      end
    end
  endfunction

  wire [`SPS_SEL_W-1:0] hsel;
  wire [`SPS_SEL_W-1:0] vsel;
  assign hsel = sps_pick(sd_sync_out_en, edhd_sync_out_en,
                         edhd_in_fmt_embedded, edhd_hsync_ctrl);
  assign vsel = sps_pick(sd_sync_out_en, edhd_sync_out_en,
                         edhd_in_fmt_embedded, edhd_vsync_ctrl);

  // ------------------------------------------------------------
  // Pipelines, all of the same fixed depth SPS_PIPE_DEPTH
  // ------------------------------------------------------------
  wire sd_h_p;
  wire sd_v_p;
  wire ext_h_p;
  wire ext_v_p;
  wire code_h_p;
  wire code_vf_p;
  wire cnt_h_p;
  wire cnt_v_p;
  wire vf_src;

  assign vf_src = std_interlaced ? code_f : code_v;

  sps_pipe u_sd_h (.clk(clk), .rstn(rstn), .din(sd_hsync), .dout(sd_h_p));
  sps_pipe u_sd_v (.clk(clk), .rstn(rstn), .din(sd_vsync_field), .dout(sd_v_p));
  sps_pipe u_ex_h (.clk(clk), .rstn(rstn), .din(hsync_pin_i), .dout(ext_h_p));
  sps_pipe u_ex_v (.clk(clk), .rstn(rstn), .din(vsync_pin_i), .dout(ext_v_p));
  sps_pipe u_cd_h (.clk(clk), .rstn(rstn), .din(code_h), .dout(code_h_p));
  sps_pipe u_cd_v (.clk(clk), .rstn(rstn), .din(vf_src), .dout(code_vf_p));
  sps_pipe u_ct_h (.clk(clk), .rstn(rstn), .din(hcnt_sync), .dout(cnt_h_p));
  sps_pipe u_ct_v (.clk(clk), .rstn(rstn), .din(vcnt_sync), .dout(cnt_v_p));

  // ------------------------------------------------------------
  // Output mux
  // ------------------------------------------------------------
  reg h_next;
  reg v_next;
  reg h_oe_next;
  reg v_oe_next;

  always @* begin
    h_oe_next = 1'b1;
    case (hsel)
      `SPS_SEL_SD:   h_next = sd_h_p;
      `SPS_SEL_PIPE: h_next = ext_h_p;
      `SPS_SEL_CODE: h_next = code_h_p;
      `SPS_SEL_CNT:  h_next = cnt_h_p;
      default: begin
        h_next    = `SPS_RST_PIN;
        h_oe_next = 1'b0;
      end
    endcase
  end

  always @* begin
    v_oe_next = 1'b1;
    case (vsel)
      `SPS_SEL_SD:   v_next = sd_v_p;
      `SPS_SEL_PIPE: v_next = ext_v_p;
      `SPS_SEL_CODE: v_next = code_vf_p;
      `SPS_SEL_CNT:  v_next = cnt_v_p;
      default: begin
        v_next    = `SPS_RST_PIN;
        v_oe_next = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registered pins
  // ------------------------------------------------------------
  reg h_reg;
  reg v_reg;
  reg h_oe_reg;
  reg v_oe_reg;
  reg ext_valid_reg;

  always @(posedge clk) begin
    if (!rstn) begin
      h_reg         <= `SPS_RST_PIN;
      v_reg         <= `SPS_RST_PIN;
      h_oe_reg      <= `SPS_RST_OE;
      v_oe_reg      <= `SPS_RST_OE;
      ext_valid_reg <= 1'b0;
    end else begin
      h_reg         <= h_next;
      v_reg         <= v_next;
      h_oe_reg      <= h_oe_next;
      v_oe_reg      <= v_oe_next;
      ext_valid_reg <= !edhd_in_fmt_embedded && !edhd_sync_out_en
                       && !sd_sync_out_en;
    end
  end

  assign hsync_pin_o    = h_reg;
  assign vsync_pin_o    = v_reg;
  assign hsync_pin_oe   = h_oe_reg;
  assign vsync_pin_oe   = v_oe_reg;
  assign edhd_ext_hsync = ext_h_p;
  assign edhd_ext_vsync = ext_v_p;
  assign edhd_ext_valid = ext_valid_reg;
endmodule // sps_sync_select
`default_nettype wire

//--- verification/sps_sync_select_props.sv
// Checker for the sync pin output select block
`timescale 1ns/100ps
`default_nettype none
module sps_sync_select_props (
  input wire logic clk, rstn, sd_sync_out_en, edhd_sync_out_en, edhd_in_fmt_embedded,
  input wire logic edhd_hsync_ctrl, edhd_vsync_ctrl, std_interlaced, sd_hsync,
  input wire logic sd_vsync_field, code_h, code_v, code_f, hcnt_sync, vcnt_sync,
  input wire logic hsync_pin_i, hsync_pin_o, hsync_pin_oe, vsync_pin_i, vsync_pin_o,
  input wire logic vsync_pin_oe, edhd_ext_hsync, edhd_ext_vsync
);
  wire sd = sd_sync_out_en;
  wire hd = edhd_sync_out_en;
  wire em = edhd_in_fmt_embedded;
  reg  [1:0] up_reg;
  wire ok = &up_reg;
  // Pipes hold real data only two edges after reset
  always @(posedge clk) up_reg <= {up_reg[0], rstn};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_tri; !sd && !hd |=> !hsync_pin_oe && !vsync_pin_oe && !hsync_pin_o && !vsync_pin_o;
  endproperty
  a_tri: assert property (p_tri) else $error("pins not released");
  property p_sd; ok && sd && !hd |=> hsync_pin_oe && vsync_pin_oe &&
    hsync_pin_o == $past(sd_hsync, 3) && vsync_pin_o == $past(sd_vsync_field, 3); endproperty
  a_sd: assert property (p_sd) else $error("sd sync wrong");
  property p_hpin; ok && hd && !em && !edhd_hsync_ctrl |=> hsync_pin_o == $past(hsync_pin_i, 3);
  endproperty
  a_hpin: assert property (p_hpin) else $error("h pipe wrong");
  property p_hcode; ok && hd && em && !edhd_hsync_ctrl |=> hsync_pin_o == $past(code_h, 3);
  endproperty
  a_hcode: assert property (p_hcode) else $error("h code wrong");
  property p_hcnt; ok && hd && edhd_hsync_ctrl |=> hsync_pin_oe && hsync_pin_o == $past(hcnt_sync, 3);
  endproperty
  a_hcnt: assert property (p_hcnt) else $error("h counter wrong");
  property p_vpin; ok && hd && !em && !edhd_vsync_ctrl |=> vsync_pin_o == $past(vsync_pin_i, 3);
  endproperty
  a_vpin: assert property (p_vpin) else $error("v pipe wrong");
  property p_vcode; ok && hd && em && !edhd_vsync_ctrl |=> vsync_pin_o ==
    ($past(std_interlaced, 3) ? $past(code_f, 3) : $past(code_v, 3)); endproperty
  a_vcode: assert property (p_vcode) else $error("v code wrong");
  property p_vcnt; ok && hd && edhd_vsync_ctrl |=> vsync_pin_oe && vsync_pin_o == $past(vcnt_sync, 3);
  endproperty
  a_vcnt: assert property (p_vcnt) else $error("v counter wrong");
  property p_ext; ok |-> edhd_ext_hsync == $past(hsync_pin_i, 2) &&
    edhd_ext_vsync == $past(vsync_pin_i, 2); endproperty
  a_ext: assert property (p_ext) else $error("ext sync wrong");
endmodule // sps_sync_select_props
bind sps_sync_select sps_sync_select_props u_props (.*);
`default_nettype wire

//--- verification/sps_src.sv
// Upstream sync source model driving the shared pins
`timescale 1ns/100ps
`default_nettype none
module sps_src (
  input  wire logic clk,
  output logic      hsync,
  output logic      vsync
);
  logic [4:0] cnt_reg = 5'h00;
  always @(posedge clk) cnt_reg <= cnt_reg + 5'h01;
  assign hsync = cnt_reg[1];
  assign vsync = cnt_reg[4];
endmodule // sps_src
`default_nettype wire

//--- verification/sps_sync_select_tb.sv
// Testbench for the sync pin output select block
`timescale 1ns/100ps
`default_nettype none
module sps_sync_select_tb;
  reg     clk = 1'b0;
  reg     rstn = 1'b0;
  reg     [5:0] c = 6'h00;
  reg     [6:0] d = 7'h00;
  wire    ho, hoe, vo, voe, hi, vi, hp, vp, val;
  integer miscompares = 0;
  integer checks = 0;
  always #4 clk = ~clk;
  assign hi = hoe ? ho : hp;
  assign vi = voe ? vo : vp;
  sps_src u_src (.clk(clk), .hsync(hp), .vsync(vp));
  sps_sync_select u_dut (.clk(clk), .rstn(rstn), .sd_sync_out_en(c[5]),
    .edhd_sync_out_en(c[4]), .edhd_in_fmt_embedded(c[3]), .edhd_hsync_ctrl(c[2]),
    .edhd_vsync_ctrl(c[1]), .std_interlaced(c[0]), .sd_hsync(d[6]), .sd_vsync_field(d[5]),
    .code_h(d[4]), .code_v(d[3]), .code_f(d[2]), .hcnt_sync(d[1]), .vcnt_sync(d[0]),
    .hsync_pin_i(hi), .hsync_pin_o(ho), .hsync_pin_oe(hoe), .vsync_pin_i(vi),
    .vsync_pin_o(vo), .vsync_pin_oe(voe), .edhd_ext_hsync(), .edhd_ext_vsync(),
    .edhd_ext_valid(val));
  task wrap_up;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Set mode and data, then look after the pipe has flushed
  task run(input [5:0] cv, input [6:0] dv, input [4:0] e);
    begin
      @(negedge clk);
      c = cv;
      d = dv;
      repeat (4) @(negedge clk);
      checks = checks + 1;
      if ({hoe, voe, ho, vo, val} !== e) begin
        miscompares = miscompares + 1;
        $display("Error %0t: pins %b expected %b", $time, {hoe, voe, ho, vo, val}, e);
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    run(6'h08, 7'h7F, 5'h00);
    run(6'h00, 7'h7F, 5'h01);
    run(6'h20, 7'h5F, 5'h1C);
    run(6'h39, 7'h14, 5'h1E);
    run(6'h18, 7'h6A, 5'h1A);
    run(6'h1E, 7'h0E, 5'h1C);
    run(6'h10, 7'h0E, 5'h1C);
    wrap_up;
  end
  initial begin
    #2000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule // sps_sync_select_tb
`default_nettype wire
